// *** pbc_consts.vh ***
// Constants for the PLL band calibration and DAC gain control block
`ifndef PBC_CONSTS_VH
`define PBC_CONSTS_VH
// ****************************************************************
// Register offsets
// ****************************************************************
`define PBC_OFS_PLL_CONTROL   5'h04
`define PBC_OFS_GAIN_A        5'h05
`define PBC_OFS_AUX_ONE       5'h06
`define PBC_OFS_GAIN_B        5'h07
`define PBC_OFS_AUX_TWO       5'h08
`define PBC_OFS_LOCK_STATUS   5'h09
`define PBC_OFS_AMP_SCALE     5'h0C
// ****************************************************************
// Field positions
// ****************************************************************
`define PBC_BAND_LSB          2
`define PBC_BAND_MSB          7
`define PBC_BAND_AUTO         6'h3F
`define PBC_LOCK_BIT          3
`define PBC_AUX_SIDE_BIT      15
`define PBC_AUX_SINK_BIT      14
`define PBC_MAG_MSB           9
`define PBC_DIV1_MSB          14
`define PBC_DIV1_LSB          13
`define PBC_DIV2_MSB          12
`define PBC_DIV2_LSB          11
`define PBC_BIAS_MSB          10
`define PBC_BIAS_LSB          8
`define PBC_DRIVE_MSB         1
`define PBC_DRIVE_LSB         0
// ****************************************************************
// Reset values
// ****************************************************************
`define PBC_RST_PLL_CONTROL   16'h0000
`define PBC_RST_GAIN          16'h0000
`define PBC_RST_AUX           16'h0000
`define PBC_RST_AMP_SCALE     16'hFFFF
// ****************************************************************
// Timing
// ****************************************************************
`define PBC_LOCK_SETTLE_US    10
`define PBC_CLK_MHZ           40
`define PBC_LOCK_SETTLE_CYC   (`PBC_LOCK_SETTLE_US * `PBC_CLK_MHZ)
`endif

// *** pbc_band_search.v ***
// Automatic PLL band search engine
`timescale 1ns/10ps
`include "pbc_consts.vh"
module pbc_band_search #(
    parameter SETTLE_CYC = `PBC_LOCK_SETTLE_CYC
) (
    // Clock and reset
    input  wire       clk_sys,
    input  wire       srst,
    // Control
    input  wire       start,
    input  wire       vco_high,
    input  wire       vco_low,
    // Result
    output reg  [5:0] band,
    output reg        busy,
    output reg        locked
);
    localparam S_IDLE   = 2'd0;
    localparam S_SETTLE = 2'd1;
    localparam S_DONE   = 2'd2;

    reg [1:0]  state;
    reg [15:0] settle_cnt;

    // Linear walk: one band step towards the comparator verdict per settle period.
    always @(posedge clk_sys) begin
        if (srst) begin
            state      <= S_IDLE;
            settle_cnt <= 16'h0000;
            band       <= 6'h1F;
            busy       <= 1'b0;
            locked     <= 1'b0;
        end else begin
            case (state)
                S_IDLE: begin
                    if (start) begin
                        state      <= S_SETTLE;
                        band       <= 6'h1F;
                        busy       <= 1'b1;
                        locked     <= 1'b0;
                        settle_cnt <= 16'h0000;
                    end
                end
                S_SETTLE: begin
                    if (!start) begin
                        state  <= S_IDLE;
                        busy   <= 1'b0;
                    end else if (settle_cnt == SETTLE_CYC[15:0] - 16'h0001) begin
                        settle_cnt <= 16'h0000;
                        // Band 62 is the top fixed band; 63 is never produced
                        if (vco_high && band < 6'h3E) begin
                            band <= band + 6'h01;
                        end else if (vco_low && band > 6'h00) begin
                            band <= band - 6'h01;
                        end else begin
                            state  <= S_DONE;
                            busy   <= 1'b0;
                            locked <= 1'b1;
                        end
                    end else begin
                        settle_cnt <= settle_cnt + 16'h0001;
                    end
                end
                S_DONE: begin
                    if (!start) begin
                        state  <= S_IDLE;
                        locked <= 1'b0;
                    end
                end
                default: begin
                    state <= S_IDLE;
                end
            endcase
        end
    end
endmodule

// *** pbc_aux_dac.v ***
// Auxiliary DAC output steering: magnitude, side and source/sink
`timescale 1ns/10ps
`include "pbc_consts.vh"
module pbc_aux_dac (
    // Clock and reset
    input  wire        clk_sys,
    input  wire        srst,
    // Control word
    input  wire [15:0] ctrl,
    // Analog cell controls
    output reg  [9:0]  magnitude,
    output reg         p_enable,
    output reg         n_enable,
    output reg         sink_mode
);
    always @(posedge clk_sys) begin
        if (srst) begin
            magnitude <= 10'h000;
            p_enable  <= 1'b1;
            n_enable  <= 1'b0;
            sink_mode <= 1'b0;
        end else begin
            magnitude <= ctrl[`PBC_MAG_MSB:0];
            // Exactly one side on; the idle side is left high impedance
            p_enable  <= ~ctrl[`PBC_AUX_SIDE_BIT];
            n_enable  <= ctrl[`PBC_AUX_SIDE_BIT];
            sink_mode <= ctrl[`PBC_AUX_SINK_BIT];
        end
    end
endmodule

// *** pbc_top.v ***
// PLL band calibration, main DAC gain and auxiliary DAC control registers
`timescale 1ns/10ps
`include "pbc_consts.vh"
module pbc_top #(
    parameter SETTLE_CYC = `PBC_LOCK_SETTLE_CYC,
    parameter DATA_W     = 16
) (
    // Clock and reset
    input  wire              clk_sys,
    input  wire              srst,
    // Register port
    input  wire [4:0]        reg_addr,
    input  wire [15:0]       reg_wdata,
    input  wire              reg_wr,
    input  wire              reg_rd,
    output reg  [15:0]       reg_rdata,
    // PLL interface
    input  wire              vco_high_pin,
    input  wire              vco_low_pin,
    input  wire              pll_locked_pin,
    output reg  [5:0]        pll_band,
    output reg  [1:0]        divider_ratio_first,
    output reg  [1:0]        divider_ratio_second,
    output reg  [2:0]        pll_bias,
    output reg  [1:0]        pll_drive,
    output reg               lock_detect,
    // Main DAC
    output reg  [9:0]        gain_a,
    output reg  [9:0]        gain_b,
    input  wire [DATA_W-1:0] sample_a,
    input  wire [DATA_W-1:0] sample_b,
    output reg  [DATA_W-1:0] scaled_a,
    output reg  [DATA_W-1:0] scaled_b,
    // Auxiliary DACs
    output reg  [9:0]        aux_one_mag,
    output reg               aux_one_p_en,
    output reg               aux_one_n_en,
    output reg               aux_one_sink,
    output reg  [9:0]        aux_two_mag,
    output reg               aux_two_p_en,
    output reg               aux_two_n_en,
    output reg               aux_two_sink
);
    // ****************************************************************
    // Registers
    // ****************************************************************
    reg  [15:0] pll_control;
    reg  [15:0] main_dac_gain_a;
    reg  [15:0] aux_dac_one_control;
    reg  [15:0] main_dac_gain_b;
    reg  [15:0] aux_dac_two_control;
    reg  [15:0] amplitude_scale_word;
    reg         search_start;

    wire [5:0]  band_field = pll_control[`PBC_BAND_MSB:`PBC_BAND_LSB];
    wire        auto_mode  = (band_field == `PBC_BAND_AUTO);
    wire [5:0]  search_band;
    wire        search_locked;
    // Pass-through fields; the controller keeps them across band rewrites
    wire [1:0]  ratio_first_field  = pll_control[`PBC_DIV1_MSB:`PBC_DIV1_LSB];
    wire [1:0]  ratio_second_field = pll_control[`PBC_DIV2_MSB:`PBC_DIV2_LSB];
    wire [2:0]  bias_field         = pll_control[`PBC_BIAS_MSB:`PBC_BIAS_LSB];
    wire [1:0]  drive_field        = pll_control[`PBC_DRIVE_MSB:`PBC_DRIVE_LSB];

    // ****************************************************************
    // Pin synchronisers
    // ****************************************************************
    reg  [2:0]  pin_meta;
    reg  [2:0]  pin_sync;

    always @(posedge clk_sys) begin
        if (srst) begin
            pin_meta <= 3'h0;
            pin_sync <= 3'h0;
        end else begin
            pin_meta <= {pll_locked_pin, vco_low_pin, vco_high_pin};
            pin_sync <= pin_meta;
        end
    end

    // ****************************************************************
    // Register writes
    // ****************************************************************
    always @(posedge clk_sys) begin
        if (srst) begin
            pll_control          <= `PBC_RST_PLL_CONTROL;
            main_dac_gain_a      <= `PBC_RST_GAIN;
            main_dac_gain_b      <= `PBC_RST_GAIN;
            aux_dac_one_control  <= `PBC_RST_AUX;
            aux_dac_two_control  <= `PBC_RST_AUX;
            amplitude_scale_word <= `PBC_RST_AMP_SCALE;
        end else if (reg_wr) begin
            case (reg_addr)
                `PBC_OFS_PLL_CONTROL: pll_control          <= reg_wdata;
                `PBC_OFS_GAIN_A:      main_dac_gain_a      <= reg_wdata;
                `PBC_OFS_GAIN_B:      main_dac_gain_b      <= reg_wdata;
                `PBC_OFS_AUX_ONE:     aux_dac_one_control  <= reg_wdata;
                `PBC_OFS_AUX_TWO:     aux_dac_two_control  <= reg_wdata;
                `PBC_OFS_AMP_SCALE:   amplitude_scale_word <= reg_wdata;
                default: begin
                end
            endcase
        end
    end

    // ****************************************************************
    // Band search control
    // ****************************************************************
    // Search runs while the field holds the auto code; leaving it aborts.
    always @(posedge clk_sys) begin
        if (srst) begin
            search_start <= 1'b0;
        end else begin
            search_start <= auto_mode;
        end
    end

    pbc_band_search #(
        .SETTLE_CYC (SETTLE_CYC)
    ) u_search (
        .clk_sys  (clk_sys),
        .srst     (srst),
        .start    (search_start),
        .vco_high (pin_sync[0]),
        .vco_low  (pin_sync[1]),
        .band     (search_band),
        .busy     (),
        .locked   (search_locked)
    );

    // ****************************************************************
    // PLL outputs
    // ****************************************************************
    always @(posedge clk_sys) begin
        if (srst) begin
            pll_band             <= 6'h00;
            divider_ratio_first  <= 2'h0;
            divider_ratio_second <= 2'h0;
            pll_bias             <= 3'h0;
            pll_drive            <= 2'h0;
            lock_detect          <= 1'b0;
        end else begin
            // Fixed code 0..62 goes straight to the VCO; auto code uses the engine
            pll_band             <= auto_mode ? search_band : band_field;
            divider_ratio_first  <= ratio_first_field;
            divider_ratio_second <= ratio_second_field;
            pll_bias             <= bias_field;
            pll_drive            <= drive_field;
            // In auto mode lock waits for the search to settle as well
            lock_detect          <= pin_sync[2] & (~auto_mode | search_locked);
        end
    end

    // ****************************************************************
    // Register reads
    // ****************************************************************
    reg  [15:0] next_rdata;
    // Completed search reports the chosen band, not the auto code
    wire [15:0] pll_readback = (auto_mode && search_locked) ?
                               {pll_control[15:8], search_band, pll_control[1:0]} :
                               pll_control;

    always @* begin
        next_rdata = 16'h0000;
        case (reg_addr)
            `PBC_OFS_PLL_CONTROL: next_rdata = pll_readback;
            `PBC_OFS_GAIN_A:      next_rdata = main_dac_gain_a;
            `PBC_OFS_GAIN_B:      next_rdata = main_dac_gain_b;
            `PBC_OFS_AUX_ONE:     next_rdata = aux_dac_one_control;
            `PBC_OFS_AUX_TWO:     next_rdata = aux_dac_two_control;
            `PBC_OFS_AMP_SCALE:   next_rdata = amplitude_scale_word;
            `PBC_OFS_LOCK_STATUS: begin
                // Only the lock bit is live; the rest of the status word reads zero
                next_rdata[`PBC_LOCK_BIT] = lock_detect;
            end
            // Unmapped offsets read as zero
            default: begin
                next_rdata = 16'h0000;
            end
        endcase
    end

    // Read data is captured once per strobe and holds until the next one
    always @(posedge clk_sys) begin
        if (srst) begin
            reg_rdata <= 16'h0000;
        end else if (reg_rd) begin
            reg_rdata <= next_rdata;
        end
    end

    // ****************************************************************
    // Main DAC gain and digital amplitude scaling
    // ****************************************************************
    // Offset binary samples: scale the signed distance from midscale so the
    // midscale code and the analog full-scale current stay untouched.
    localparam [DATA_W-1:0] MIDSCALE = {1'b1, {(DATA_W-1){1'b0}}};

    wire [DATA_W-1:0] sample_ch [0:1];
    wire [DATA_W-1:0] swing_ch  [0:1];

    assign sample_ch[0] = sample_a;
    assign sample_ch[1] = sample_b;

    genvar ch;
    generate
        for (ch = 0; ch < 2; ch = ch + 1) begin : g_scale
            wire signed [DATA_W:0]    dev;
            wire signed [DATA_W+17:0] prod;
            assign dev  = $signed({1'b0, sample_ch[ch]}) - $signed({1'b0, MIDSCALE});
            assign prod = dev * $signed({1'b0, amplitude_scale_word});
            // Slicing floors the result; a bias under one code is accepted
            assign swing_ch[ch] = prod[DATA_W+15:16];
        end
    endgenerate

    always @(posedge clk_sys) begin
        if (srst) begin
            gain_a   <= 10'h000;
            gain_b   <= 10'h000;
            scaled_a <= MIDSCALE;
            scaled_b <= MIDSCALE;
        end else begin
            gain_a   <= main_dac_gain_a[9:0];
            gain_b   <= main_dac_gain_b[9:0];
            scaled_a <= MIDSCALE + swing_ch[0];
            scaled_b <= MIDSCALE + swing_ch[1];
        end
    end

    // ****************************************************************
    // Auxiliary DACs
    // ****************************************************************
    wire [9:0] one_mag;
    wire       one_p;
    wire       one_n;
    wire       one_sink;
    wire [9:0] two_mag;
    wire       two_p;
    wire       two_n;
    wire       two_sink;

    pbc_aux_dac u_aux_one (
        .clk_sys   (clk_sys),
        .srst      (srst),
        .ctrl      (aux_dac_one_control),
        .magnitude (one_mag),
        .p_enable  (one_p),
        .n_enable  (one_n),
        .sink_mode (one_sink)
    );

    pbc_aux_dac u_aux_two (
        .clk_sys   (clk_sys),
        .srst      (srst),
        .ctrl      (aux_dac_two_control),
        .magnitude (two_mag),
        .p_enable  (two_p),
        .n_enable  (two_n),
        .sink_mode (two_sink)
    );

    // Retimed so every top output leaves from a flop
    always @(posedge clk_sys) begin
        if (srst) begin
            aux_one_mag  <= 10'h000;
            aux_one_p_en <= 1'b1;
            aux_one_n_en <= 1'b0;
            aux_one_sink <= 1'b0;
            aux_two_mag  <= 10'h000;
            aux_two_p_en <= 1'b1;
            aux_two_n_en <= 1'b0;
            aux_two_sink <= 1'b0;
        end else begin
            aux_one_mag  <= one_mag;
            aux_one_p_en <= one_p;
            aux_one_n_en <= one_n;
            aux_one_sink <= one_sink;
            aux_two_mag  <= two_mag;
            aux_two_p_en <= two_p;
            aux_two_n_en <= two_n;
            aux_two_sink <= two_sink;
        end
    end
endmodule

// *** pbc_monitor.sv ***
// Port-level assertions for the PLL band calibration and DAC gain block
`timescale 1ns/10ps
module pbc_monitor #(
    parameter DATA_W = 16
) (
    // Clock and reset
    input wire              clk_sys,
    input wire              srst,
    // Register port
    input wire [4:0]        reg_addr,
    input wire [15:0]       reg_wdata,
    input wire              reg_wr,
    input wire              reg_rd,
    input wire [15:0]       reg_rdata,
    // PLL and DAC inputs and outputs
    input wire              pll_locked_pin,
    input wire              lock_detect,
    input wire [9:0]        gain_a,
    input wire [DATA_W-1:0] sample_a,
    input wire [DATA_W-1:0] scaled_a,
    input wire [9:0]        aux_one_mag,
    input wire              aux_one_p_en,
    input wire              aux_one_n_en,
    input wire              aux_one_sink,
    input wire              aux_two_p_en,
    input wire              aux_two_n_en
);
    localparam [DATA_W-1:0] MID = {1'b1, {(DATA_W-1){1'b0}}};
    reg  [15:0] last_aux;
    reg  [9:0]  last_gain;
    wire        gain_wr = reg_wr && (reg_addr == 5'h05);
    wire        aux_wr  = reg_wr && (reg_addr == 5'h06);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (srst);
    // Shadow of the last written words, so loads can be compared after their latency
    always @(posedge clk_sys) begin
        if (aux_wr)
            last_aux <= reg_wdata;
        if (gain_wr)
            last_gain <= reg_wdata[9:0];
    end
    aux_one_excl_a: assert property (aux_one_p_en != aux_one_n_en)
        else $error("aux one side enables not exclusive");
    aux_two_excl_a: assert property (aux_two_p_en != aux_two_n_en)
        else $error("aux two side enables not exclusive");
    aux_load_a: assert property (aux_wr |-> ##[2:3] (aux_one_mag == last_aux[9:0] &&
        aux_one_n_en == last_aux[15] && aux_one_sink == last_aux[14]))
        else $error("aux one outputs do not follow written word");
    gain_load_a: assert property (gain_wr |-> ##[1:2] gain_a == last_gain)
        else $error("gain a does not follow written word");
    gain_hold_a: assert property ($changed(gain_a) |-> $past(gain_wr) || $past(gain_wr, 2))
        else $error("gain a changed without a write");
    mid_hold_a: assert property (sample_a == MID |=> scaled_a == MID)
        else $error("midscale sample not kept at midscale");
    rdata_hold_a: assert property ($changed(reg_rdata) |-> $past(reg_rd) || $past(reg_rd, 2))
        else $error("read data changed without a read");
    lock_drop_a: assert property (!pll_locked_pin [*3] |=> !lock_detect)
        else $error("lock output high without lock");
    lock_rise_a: assert property ($rose(lock_detect) |-> $past(pll_locked_pin, 3))
        else $error("lock output rose without lock input");
    cover property ($rose(lock_detect));
    cover property (aux_one_n_en && aux_one_sink);
    cover property (reg_wr && reg_addr == 5'h0C);
endmodule
bind pbc_top pbc_monitor #(.DATA_W(DATA_W)) u_mon (
    .clk_sys(clk_sys), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .pll_locked_pin(pll_locked_pin), .lock_detect(lock_detect), .gain_a(gain_a),
    .sample_a(sample_a), .scaled_a(scaled_a), .aux_one_mag(aux_one_mag),
    .aux_one_p_en(aux_one_p_en), .aux_one_n_en(aux_one_n_en), .aux_one_sink(aux_one_sink),
    .aux_two_p_en(aux_two_p_en), .aux_two_n_en(aux_two_n_en));

// *** pll_band_cal_and_dac_gain_ctrl_tb.sv ***
// Self-checking bench for the PLL band calibration and DAC gain block
`timescale 1ns/10ps
module pll_band_cal_and_dac_gain_ctrl_tb;
    reg         clk_sys = 1'b0;
    reg         srst = 1'b1;
    reg  [4:0]  reg_addr = 5'h00;
    reg  [15:0] reg_wdata = 16'h0000;
    reg         reg_wr = 1'b0;
    reg         reg_rd = 1'b0;
    reg         vco_high_pin = 1'b0;
    reg         vco_low_pin = 1'b0;
    reg         pll_locked_pin = 1'b0;
    reg  [15:0] sample_a = 16'h8000;
    reg  [15:0] sample_b = 16'h8000;
    reg  [15:0] rd;
    wire [15:0] reg_rdata, scaled_a, scaled_b;
    wire [5:0]  pll_band;
    wire [1:0]  divider_ratio_first, divider_ratio_second, pll_drive;
    wire [2:0]  pll_bias;
    wire [9:0]  gain_a, gain_b, aux_one_mag, aux_two_mag;
    wire        lock_detect, aux_one_p_en, aux_one_n_en, aux_one_sink;
    wire        aux_two_p_en, aux_two_n_en, aux_two_sink;
    integer     errors = 0;
    integer     comparisons = 0;
    integer     cycles = 0;

    always #12.5 clk_sys = ~clk_sys;

    // Short settle count keeps the band search to a few dozen cycles
    pbc_top #(.SETTLE_CYC(4)) DUT (
        .clk_sys(clk_sys), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .vco_high_pin(vco_high_pin), .vco_low_pin(vco_low_pin),
        .pll_locked_pin(pll_locked_pin), .pll_band(pll_band),
        .divider_ratio_first(divider_ratio_first), .divider_ratio_second(divider_ratio_second),
        .pll_bias(pll_bias), .pll_drive(pll_drive), .lock_detect(lock_detect),
        .gain_a(gain_a), .gain_b(gain_b), .sample_a(sample_a), .sample_b(sample_b),
        .scaled_a(scaled_a), .scaled_b(scaled_b), .aux_one_mag(aux_one_mag),
        .aux_one_p_en(aux_one_p_en), .aux_one_n_en(aux_one_n_en), .aux_one_sink(aux_one_sink),
        .aux_two_mag(aux_two_mag), .aux_two_p_en(aux_two_p_en), .aux_two_n_en(aux_two_n_en),
        .aux_two_sink(aux_two_sink));

    task wrap_up;
        begin
            $display("comparisons %0d errors %0d", comparisons, errors);
            if (errors == 0 && comparisons > 0)
                $display("[ PASS ]");
            else
                $display("[ FAIL ]");
            $finish;
        end
    endtask

    task check(input string nm, input [15:0] exp, input [15:0] got);
        begin
            comparisons = comparisons + 1;
            if (got !== exp) begin
                errors = errors + 1;
                $display("[ERR] %0s expected %h seen %h", nm, exp, got);
            end
        end
    endtask

    task settle(input integer n);
        repeat (n) @(negedge clk_sys);
    endtask

    task wr(input [4:0] a, input [15:0] d);
        begin
            @(negedge clk_sys);
            reg_addr = a;
            reg_wdata = d;
            reg_wr = 1'b1;
            @(negedge clk_sys);
            reg_wr = 1'b0;
        end
    endtask

    task rdreg(input [4:0] a);
        begin
            @(negedge clk_sys);
            reg_addr = a;
            reg_rd = 1'b1;
            @(negedge clk_sys);
            reg_rd = 1'b0;
            settle(1);
            rd = reg_rdata;
        end
    endtask

    // Controller side of the temperature rewrite: bracket 0 is the coldest
    function [5:0] adj(input [5:0] rb, input integer br);
        integer v;
        begin
            if (rb < 32)
                v = rb + 2 - br;
            else
                v = rb + 3 - br;
            if (v > 62)
                v = 62;
            if (v < 0)
                v = 0;
            adj = v[5:0];
        end
    endfunction

    task set_band(input [5:0] ex);
        begin
            wr(5'h04, (rd & 16'hFF03) | {8'h00, ex, 2'b00});
            settle(2);
            check("band rewrite", {10'h000, ex}, {10'h000, pll_band});
        end
    endtask

    task t_regs;
        begin
            rdreg(5'h0C);
            check("scale reset", 16'hFFFF, rd);
            wr(5'h05, 16'hFE01);
            wr(5'h07, 16'h03FF);
            settle(2);
            check("gain_a", 16'h0201, {6'h00, gain_a});
            check("gain_b", 16'h03FF, {6'h00, gain_b});
            rdreg(5'h07);
            check("gain_b read", 16'h03FF, rd);
            rdreg(5'h0A);
            check("unmapped read", 16'h0000, rd);
            wr(5'h09, 16'hFFFF);
            rdreg(5'h09);
            check("status no lock", 16'h0000, rd);
            $display("test registers done");
        end
    endtask

    task t_aux;
        integer i;
        reg [15:0] w;
        reg [15:0] w2;
        begin
            for (i = 0; i < 4; i = i + 1) begin
                // Sink choice stays fixed per channel; only side and magnitude move
                w = {i[0], 1'b1, 4'h0, 10'h2A5 + i[9:0]};
                w2 = w ^ 16'hC3FF;
                wr(5'h06, w);
                wr(5'h08, w2);
                settle(3);
                check("aux one", {~w[15], w[15], w[14], 3'h0, w[9:0]},
                      {aux_one_p_en, aux_one_n_en, aux_one_sink, 3'h0, aux_one_mag});
                check("aux two", {~w2[15], w2[15], w2[14], 3'h0, w2[9:0]},
                      {aux_two_p_en, aux_two_n_en, aux_two_sink, 3'h0, aux_two_mag});
            end
            $display("test aux done");
        end
    endtask

    task t_scale;
        begin
            sample_a = 16'hC000;
            sample_b = 16'h4000;
            wr(5'h0C, 16'h8000);
            settle(2);
            check("scaled_a", 16'hA000, scaled_a);
            check("scaled_b", 16'h6000, scaled_b);
            sample_a = 16'h8000;
            settle(2);
            check("scaled mid", 16'h8000, scaled_a);
            check("gain kept", 16'h0201, {6'h00, gain_a});
            $display("test scaling done");
        end
    endtask

    task t_auto;
        integer n;
        integer b;
        reg [5:0] rb;
        begin
            pll_locked_pin = 1'b1;
            vco_high_pin = 1'b1;
            wr(5'h04, 16'h4BFF);
            settle(2);
            check("dividers", 16'h0009,
                  {12'h000, divider_ratio_first, divider_ratio_second});
            n = 0;
            while (pll_band !== 6'd40 && n < 2000) begin
                settle(1);
                n = n + 1;
            end
            vco_high_pin = 1'b0;
            n = 0;
            // Far below the 2000-cycle (50 us) allowance; a miss counts as a mismatch
            while (lock_detect !== 1'b1 && n < 2000) begin
                settle(1);
                n = n + 1;
            end
            check("lock pin", 16'h0001, {15'h0000, lock_detect});
            rdreg(5'h09);
            check("lock bit", 16'h0008, rd);
            rdreg(5'h04);
            rb = rd[7:2];
            check("band found", 16'h0001, {15'h0000, rb >= 6'd40 && rb <= 6'd42});
            check("band field", {10'h000, pll_band}, {10'h000, rb});
            check("other fields", 16'h4B03, rd & 16'hFF03);
            for (b = 0; b < 5; b = b + 1)
                set_band(adj(rb, b));
            set_band(adj(6'd20, 0));
            set_band(adj(6'd20, 3));
            set_band(adj(6'd61, 0));
            // Restart mid-run, then replay the stored band as a controller without sensing
            srst = 1'b1;
            settle(4);
            srst = 1'b0;
            check("dividers reset", 16'h0000,
                  {12'h000, divider_ratio_first, divider_ratio_second});
            set_band(rb);
            check("dividers kept", 16'h0009,
                  {12'h000, divider_ratio_first, divider_ratio_second});
            $display("test band search done");
        end
    endtask

    always @(posedge clk_sys) begin
        cycles = cycles + 1;
        if (cycles == 20000) begin
            errors = errors + 1;
            $display("[ERR] run length expected under 20000 seen 20000");
            wrap_up;
        end
    end

    initial begin
        settle(16);
        srst = 1'b0;
        t_regs;
        t_aux;
        t_scale;
        t_auto;
        wrap_up;
    end
endmodule
